// [src/dbs_if.sv]
`timescale 1ns/10ps
// Joins the sizer to the processor glue and the peripheral side
interface dbs_if;
  // Processor bus control
  logic        sel_n;
  logic [1:0]  access_size_code;
  logic [1:0]  cpu_byte_offset;
  logic        rd_wr;
  logic        access_done_ack_n;
  // Processor data, per-lane drivers and resolved level
  logic [31:0] dev_cpu_data_o;
  logic [3:0]  dev_cpu_data_oe_n;
  logic [31:0] sys_cpu_data_o;
  logic [3:0]  sys_cpu_data_oe_n;
  logic [31:0] cpu_data;
  // Lower-half transceiver control
  logic        xcvr_en_n;
  logic        xcvr_dir;
  // Peripheral bus
  logic [1:0]  periph_byte_addr;
  logic        upper_byte_write_en_n;
  logic        lower_byte_write_en_n;
  logic        single_byte_write_en_n;
  logic        periph_data_strobe_n;
  logic [1:0]  periph_width_ack_n;
  logic [15:0] dev_periph_data_o;
  logic        dev_periph_data_oe_n;
  logic [15:0] sys_periph_data_o;
  logic        sys_periph_data_oe_n;
  logic [15:0] periph_data;

  // Wire level; an undriven lane reads as zero
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign cpu_data[i*8 +: 8] =
      !dev_cpu_data_oe_n[i] ? dev_cpu_data_o[i*8 +: 8] :
      !sys_cpu_data_oe_n[i] ? sys_cpu_data_o[i*8 +: 8] : 8'h00;
  end
  assign periph_data = !dev_periph_data_oe_n ? dev_periph_data_o :
                       !sys_periph_data_oe_n ? sys_periph_data_o : 16'h0000;

  modport dev (
    input  sel_n, access_size_code, cpu_byte_offset, rd_wr, cpu_data,
    input  periph_width_ack_n, periph_data,
    output access_done_ack_n, dev_cpu_data_o, dev_cpu_data_oe_n,
    output periph_byte_addr, upper_byte_write_en_n, lower_byte_write_en_n,
    output single_byte_write_en_n, periph_data_strobe_n,
    output dev_periph_data_o, dev_periph_data_oe_n
  );
  modport sys (
    output sel_n, access_size_code, cpu_byte_offset, rd_wr,
    output sys_cpu_data_o, sys_cpu_data_oe_n, xcvr_en_n, xcvr_dir,
    output periph_width_ack_n, sys_periph_data_o, sys_periph_data_oe_n,
    input  access_done_ack_n, cpu_data, periph_byte_addr,
    input  upper_byte_write_en_n, lower_byte_write_en_n,
    input  single_byte_write_en_n, periph_data_strobe_n, periph_data
  );
endinterface

// [src/dbs_pkg.sv]
package dbs_pkg;
  // Access size codes on the processor bus
  localparam logic [1:0] SIZE_LONG_A = 2'h0;
  localparam logic [1:0] SIZE_BYTE   = 2'h1;
  localparam logic [1:0] SIZE_WORD   = 2'h2;
  localparam logic [1:0] SIZE_LONG_B = 2'h3;
  // Width codes on the peripheral acknowledge pair (active low pins)
  localparam logic [1:0] ACK_W32  = 2'h0;
  localparam logic [1:0] ACK_W16  = 2'h1;
  localparam logic [1:0] ACK_W8   = 2'h2;
  localparam logic [1:0] ACK_WAIT = 2'h3;
  // Byte counts
  localparam logic [2:0] NB_BYTE = 3'h1;
  localparam logic [2:0] NB_WORD = 3'h2;
  localparam logic [2:0] NB_LONG = 3'h4;
  // Default wait states of the far-end peripheral
  localparam int WAIT_DEFAULT = 2;
endpackage

// [src/dbs_sizer.sv]
`timescale 1ns/10ps
// Device end: splits one processor access into peripheral transfers
module dbs_sizer
  import dbs_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Bus pair
  dbs_if.dev       BUS,
  // Status
  output logic     BUSY,
  output logic [1:0] LAST_WIDTH
);

  // One-hot sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_XFER = 5'h02,
    ST_NEXT = 5'h04,
    ST_DONE = 5'h08,
    ST_WREL = 5'h10
  } dbs_state_t;

  dbs_state_t  state_r, state_nxt;

  // Captured access and the current transfer
  logic [1:0]  pa_r;
  logic [2:0]  left_r;
  logic        rd_r;
  logic [31:0] wdat_r;
  logic [15:0] wlane_r;

  // Read latches and the learned port width
  logic [7:0]  rbyte_r [4];
  logic [1:0]  width_r;
  logic        width_ok_r;

  // Per-cycle decode
  logic [2:0]  moved;
  logic        ack_seen;
  logic        xfer_end;
  logic        last_xfer;
  logic [2:0]  start_bytes;
  logic        upper_we;
  logic        lower_we;
  logic        single_we;

  // Both acknowledges high means the peripheral is still busy
  assign ack_seen = BUS.periph_width_ack_n != ACK_WAIT;
  // A transfer ends in the strobe cycle that sees a width code
  assign xfer_end = state_r == ST_XFER && ack_seen;

  // Size code to byte count
  always_comb begin
    unique case (BUS.access_size_code)
      SIZE_BYTE: start_bytes = NB_BYTE;
      SIZE_WORD: start_bytes = NB_WORD;
      default:   start_bytes = NB_LONG;
    endcase
  end

  // Bytes moved by this transfer, from the reported width. A 16-bit
  // port takes halfwords only from an even address; anything else
  // goes a byte at a time, which keeps the lane steering simple.
  always_comb begin
    moved = NB_BYTE;
    unique case (BUS.periph_width_ack_n)
      ACK_W32: moved = left_r;
      ACK_W16: moved = (pa_r[0] || left_r == NB_BYTE) ? NB_BYTE : NB_WORD;
      default: moved = NB_BYTE;
    endcase
  end
  assign last_xfer = (left_r == moved);

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (!BUS.sel_n) state_nxt = ST_XFER;
      ST_XFER: if (ack_seen) state_nxt = last_xfer ? ST_DONE : ST_NEXT;
      ST_NEXT: state_nxt = ST_XFER;
      ST_DONE: state_nxt = ST_WREL;
      ST_WREL: if (BUS.sel_n) state_nxt = ST_IDLE;
    endcase
  end

  // State register, one bus clock throughout
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Top lane takes the addressed byte, the next lane its halfword pair
  function automatic logic [15:0] lane_pick(input logic [31:0] w,
                                            input logic [1:0]  pa);
    lane_pick[15:8] = w[8*(3 - pa) +: 8];
    lane_pick[7:0]  = w[8*(2 - {pa[1], 1'b0}) +: 8];
  endfunction

  // Access capture: direction and write data for the whole access
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rd_r   <= 1'b1;
      wdat_r <= 32'h0000_0000;
    end else if (state_r == ST_IDLE && !BUS.sel_n) begin
      rd_r   <= BUS.rd_wr;
      wdat_r <= BUS.cpu_data;
    end
  end

  // Per-transfer address advance; the write lanes are loaded with the
  // address so they stand unchanged for the whole strobe
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pa_r    <= 2'h0;
      left_r  <= 3'h0;
      wlane_r <= 16'h0000;
    end else if (state_r == ST_IDLE && !BUS.sel_n) begin
      pa_r    <= BUS.cpu_byte_offset;
      left_r  <= start_bytes;
      wlane_r <= lane_pick(BUS.cpu_data, BUS.cpu_byte_offset);
    end else if (xfer_end && !last_xfer) begin
      pa_r    <= pa_r + moved[1:0];
      left_r  <= left_r - moved;
      wlane_r <= lane_pick(wdat_r, pa_r + moved[1:0]);
    end
  end

  // Port width becomes known at the first acknowledge
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      width_r    <= ACK_W32;
      width_ok_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      width_ok_r <= 1'b0;
    end else if (state_r == ST_XFER && ack_seen) begin
      width_r    <= BUS.periph_width_ack_n;
      width_ok_r <= 1'b1;
    end
  end

  // Read byte latches; byte 0 is the most significant
  for (genvar i = 0; i < 4; i++) begin : g_rbyte
    logic       take;
    logic [7:0] src;
    assign take = state_r == ST_XFER && ack_seen && rd_r &&
                  (3'(i) >= {1'b0, pa_r}) &&
                  (3'(i) < ({1'b0, pa_r} + moved));
    // 8-bit ports always answer on the top lane
    assign src = (BUS.periph_width_ack_n == ACK_W8 || (i % 2) == 0) ?
                 BUS.periph_data[15:8] : BUS.periph_data[7:0];
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        rbyte_r[i] <= 8'h00;
      end else if (take) begin
        rbyte_r[i] <= src;
      end
    end
  end

  // Processor acknowledge, only once every transfer has finished
  assign BUS.access_done_ack_n = (state_r != ST_DONE);

  // Read data back to the processor. The lower half stays off for a
  // 32-bit port because the outside transceivers own those lanes.
  always_comb begin
    BUS.dev_cpu_data_o = {rbyte_r[0], rbyte_r[1], rbyte_r[2], rbyte_r[3]};
    BUS.dev_cpu_data_oe_n = 4'hF;
    if (state_r == ST_DONE && rd_r) begin
      BUS.dev_cpu_data_oe_n[3:2] = 2'h0;
      if (width_ok_r && width_r != ACK_W32) begin
        BUS.dev_cpu_data_oe_n[1:0] = 2'h0;
      end
    end
  end

  // Peripheral controls; strobe drops one cycle between transfers
  assign BUS.periph_byte_addr     = pa_r;
  assign BUS.periph_data_strobe_n = (state_r != ST_XFER);
  // Enables are offered for every width because the width is only
  // known when the transfer ends; the port uses its own set
  always_comb begin
    upper_we  = 1'b0;
    lower_we  = 1'b0;
    single_we = 1'b0;
    if (state_r == ST_XFER && !rd_r) begin
      upper_we  = !pa_r[0];
      lower_we  = pa_r[0] || left_r != NB_BYTE;
      single_we = 1'b1;
    end
  end
  assign BUS.upper_byte_write_en_n  = !upper_we;
  assign BUS.lower_byte_write_en_n  = !lower_we;
  assign BUS.single_byte_write_en_n = !single_we;

  // Write lanes come straight from their register
  always_comb begin
    BUS.dev_periph_data_o    = wlane_r;
    BUS.dev_periph_data_oe_n = !(state_r == ST_XFER && !rd_r);
  end

  // Status
  assign BUSY       = (state_r != ST_IDLE);
  assign LAST_WIDTH = width_r;

endmodule

// [src/dbs_sys_end.sv]
`timescale 1ns/10ps
// Far end: processor decode glue, lower transceivers and a peripheral
module dbs_sys_end
  import dbs_pkg::*;
#(
  parameter int WAIT_CYCLES = WAIT_DEFAULT
)(
  // Clock and reset
  input wire logic   CLK_SYS,
  input wire logic   RST,
  // Bus pair
  dbs_if.sys         BUS,
  // Processor request
  input wire logic        CPU_START,
  input wire logic [1:0]  CPU_SIZE,
  input wire logic [1:0]  CPU_OFFSET,
  input wire logic        CPU_READ,
  input wire logic [31:0] CPU_WDATA,
  output logic            CPU_DONE,
  output logic [31:0]     CPU_RDATA,
  // Peripheral model
  input wire logic [1:0]  PORT_WIDTH,
  input wire logic [31:0] PER_RDATA,
  output logic [31:0]     PER_WDATA
);

  logic        act_r;
  logic [1:0]  size_r;
  logic [1:0]  off_r;
  logic        rd_r;
  logic [31:0] wd_r;
  logic [7:0]  wcnt_r;
  logic [1:0]  ack_r;
  logic        is32;

  // Select held from transfer start until the acknowledge
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      act_r  <= 1'b0;
      size_r <= SIZE_LONG_A;
      off_r  <= 2'h0;
      rd_r   <= 1'b1;
      wd_r   <= 32'h0000_0000;
    end else if (!act_r && CPU_START) begin
      act_r  <= 1'b1;
      size_r <= CPU_SIZE;
      off_r  <= CPU_OFFSET;
      rd_r   <= CPU_READ;
      wd_r   <= CPU_WDATA;
    end else if (act_r && !BUS.access_done_ack_n) begin
      act_r  <= 1'b0;
    end
  end
  assign BUS.sel_n            = !act_r;
  assign BUS.access_size_code = size_r;
  assign BUS.cpu_byte_offset  = off_r;
  assign BUS.rd_wr            = rd_r;

  // Lower transceivers only for a port answering 32 bits wide
  assign is32          = (PORT_WIDTH == ACK_W32);
  assign BUS.xcvr_en_n = !(act_r && is32);
  assign BUS.xcvr_dir  = rd_r;

  // Processor data: all lanes on writes, lower lanes via transceivers
  always_comb begin
    BUS.sys_cpu_data_o    = rd_r ? {16'h0000, PER_RDATA[15:0]} : wd_r;
    BUS.sys_cpu_data_oe_n = 4'hF;
    if (act_r && !rd_r) begin
      BUS.sys_cpu_data_oe_n = 4'h0;
    end else if (!BUS.xcvr_en_n && BUS.xcvr_dir) begin
      BUS.sys_cpu_data_oe_n = 4'hC;
    end
  end

  // Processor completion
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CPU_DONE  <= 1'b0;
      CPU_RDATA <= 32'h0000_0000;
    end else begin
      CPU_DONE <= act_r && !BUS.access_done_ack_n;
      if (act_r && !BUS.access_done_ack_n && rd_r) begin
        CPU_RDATA <= BUS.cpu_data;
      end
    end
  end

  // Peripheral: waits, then reports its width until the strobe drops
  always_ff @(posedge CLK_SYS) begin
    if (RST || BUS.periph_data_strobe_n) begin
      wcnt_r <= 8'h00;
      ack_r  <= ACK_WAIT;
    end else if (wcnt_r == 8'(WAIT_CYCLES)) begin
      ack_r  <= PORT_WIDTH;
    end else begin
      wcnt_r <= wcnt_r + 8'h01;
    end
  end
  assign BUS.periph_width_ack_n = ack_r;

  // Peripheral read lanes follow the byte address
  always_comb begin
    BUS.sys_periph_data_o[15:8] = PER_RDATA[8*(3 - BUS.periph_byte_addr) +: 8];
    BUS.sys_periph_data_o[7:0]  =
      PER_RDATA[8*(2 - {BUS.periph_byte_addr[1], 1'b0}) +: 8];
    if (PORT_WIDTH == ACK_W16 && BUS.periph_byte_addr[0]) begin
      BUS.sys_periph_data_o[7:0] = BUS.sys_periph_data_o[15:8];
    end
    BUS.sys_periph_data_oe_n = !(!BUS.periph_data_strobe_n && rd_r);
  end

  // Peripheral write capture at the acknowledge edge
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PER_WDATA <= 32'h0000_0000;
    end else if (!BUS.periph_data_strobe_n && ack_r != ACK_WAIT && !rd_r) begin
      unique case (PORT_WIDTH)
        ACK_W8: begin
          if (!BUS.single_byte_write_en_n) begin
            PER_WDATA[8*(3 - BUS.periph_byte_addr) +: 8] <=
              BUS.periph_data[15:8];
          end
        end
        ACK_W16: begin
          if (!BUS.upper_byte_write_en_n) begin
            PER_WDATA[8*(3 - {BUS.periph_byte_addr[1], 1'b0}) +: 8] <=
              BUS.periph_data[15:8];
          end
          if (!BUS.lower_byte_write_en_n) begin
            PER_WDATA[8*(2 - {BUS.periph_byte_addr[1], 1'b0}) +: 8] <=
              BUS.periph_data[7:0];
          end
        end
        default: begin
          PER_WDATA <= {BUS.periph_data, BUS.cpu_data[15:0]};
        end
      endcase
    end
  end

endmodule

// [tb/dbs_sizer_tb_top.sv]
`timescale 1ns/10ps
// Runs both ends of the sizer against each other
module dbs_sizer_tb_top
  import dbs_pkg::*;
;
  typedef struct packed {
    logic [1:0] sz;
    logic [1:0] off;
    logic       rd;
    logic [1:0] w;
    logic [2:0] nxf;
  } dbs_row_t;
  localparam int NR = 12;
  // Size, offset, read, width code, expected transfer count
  localparam dbs_row_t ROWS [NR] = '{
    '{2'h0, 2'h0, 1'h1, 2'h0, 3'h1}, '{2'h3, 2'h0, 1'h0, 2'h0, 3'h1},
    '{2'h2, 2'h2, 1'h1, 2'h0, 3'h1}, '{2'h1, 2'h1, 1'h0, 2'h0, 3'h1},
    '{2'h0, 2'h0, 1'h1, 2'h1, 3'h2}, '{2'h3, 2'h0, 1'h0, 2'h1, 3'h2},
    '{2'h2, 2'h2, 1'h0, 2'h1, 3'h1}, '{2'h1, 2'h3, 1'h1, 2'h1, 3'h1},
    '{2'h3, 2'h0, 1'h1, 2'h2, 3'h4}, '{2'h0, 2'h0, 1'h0, 2'h2, 3'h4},
    '{2'h2, 2'h2, 1'h1, 2'h2, 3'h2}, '{2'h1, 2'h2, 1'h0, 2'h2, 3'h1}};

  logic        CLK_SYS = 1'b0;
  logic        RST = 1'b1;
  logic        start = 1'b0;
  logic [1:0]  size;
  logic [1:0]  offs;
  logic [1:0]  pw;
  logic [1:0]  lw;
  logic [1:0]  a;
  logic        rd;
  logic        done;
  logic        busy;
  logic        strb_q = 1'b1;
  logic [31:0] wd;
  logic [31:0] pr;
  logic [31:0] rdata;
  logic [31:0] pwdata;
  int          errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          nxf = 0;
  dbs_row_t    cur;

  always #10 CLK_SYS = ~CLK_SYS;

  dbs_if dbs_if_i ();
  wire [15:0] pd = dbs_if_i.periph_data;
  dbs_sizer dbs_sizer_i (.CLK_SYS(CLK_SYS), .RST(RST), .BUS(dbs_if_i),
    .BUSY(busy), .LAST_WIDTH(lw));
  // Slowest legal peripheral, so every transfer is stretched
  dbs_sys_end #(.WAIT_CYCLES(3)) dbs_sys_end_i (.CLK_SYS(CLK_SYS),
    .RST(RST), .BUS(dbs_if_i), .CPU_START(start), .CPU_SIZE(size),
    .CPU_OFFSET(offs), .CPU_READ(rd), .CPU_WDATA(wd), .CPU_DONE(done),
    .CPU_RDATA(rdata), .PORT_WIDTH(pw), .PER_RDATA(pr),
    .PER_WDATA(pwdata));
  dbs_sva dbs_sva_i (.CLK_SYS(CLK_SYS), .RST(RST),
    .sel_n(dbs_if_i.sel_n), .rd_wr(dbs_if_i.rd_wr),
    .access_done_ack_n(dbs_if_i.access_done_ack_n),
    .dev_cpu_data_oe_n(dbs_if_i.dev_cpu_data_oe_n),
    .periph_byte_addr(dbs_if_i.periph_byte_addr),
    .upper_byte_write_en_n(dbs_if_i.upper_byte_write_en_n),
    .lower_byte_write_en_n(dbs_if_i.lower_byte_write_en_n),
    .single_byte_write_en_n(dbs_if_i.single_byte_write_en_n),
    .periph_data_strobe_n(dbs_if_i.periph_data_strobe_n),
    .periph_width_ack_n(dbs_if_i.periph_width_ack_n),
    .dev_periph_data_oe_n(dbs_if_i.dev_periph_data_oe_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Byte lanes touched by an access; a long always covers all four
  function automatic logic [31:0] lanes(input dbs_row_t r);
    int n;
    int b;
    n = r.sz == SIZE_BYTE ? 1 : r.sz == SIZE_WORD ? 2 : 4;
    b = n == 4 ? 0 : r.off;
    lanes = 32'h0;
    for (int k = 0; k < 4; k++)
      if (k >= b && k < b + n)
        lanes[31-8*k -: 8] = 8'hFF;
  endfunction

  // Everything idle and undriven
  task automatic chk_idle();
    check({23'h0, dbs_if_i.dev_cpu_data_oe_n, dbs_if_i.dev_periph_data_oe_n,
      dbs_if_i.periph_data_strobe_n, dbs_if_i.access_done_ack_n,
      dbs_if_i.sel_n, busy}, 32'h1FE);
  endtask

  // One access; mode 1 repeats the request mid-way, mode 2 resets
  task automatic access(input dbs_row_t r, input int mode);
    logic [31:0] m;
    @(negedge CLK_SYS);
    cur = r;
    size = r.sz;
    offs = r.off;
    rd = r.rd;
    pw = r.w;
    wd = {4{tests_run[7:0]}} ^ 32'h1E2D3C4B;
    pr = ~wd;
    nxf = 0;
    start = 1'b1;
    for (int t = 0; t < 80; t++) begin
      @(negedge CLK_SYS);
      if (done === 1'b1 || (mode == 2 && t == 6))
        break;
      if (mode == 0 && t == 1)
        check({31'h0, busy}, 32'h1);
      start = mode == 1 && t == 4;
      if (mode == 2 && t == 4)
        RST = 1'b1;
    end
    if (mode != 2) begin
      m = lanes(r);
      check({31'h0, done}, 32'h1);
      check(nxf, {29'h0, r.nxf});
      check({30'h0, lw}, {30'h0, r.w});
      if (r.rd)
        check(rdata & m, pr & m);
      else
        check(pwdata & m, wd & m);
    end
  endtask

  // Counts transfers and checks the write lanes of 8- and 16-bit ports while strobed
  always @(negedge CLK_SYS) begin
    a = dbs_if_i.periph_byte_addr;
    if (!dbs_if_i.periph_data_strobe_n && strb_q)
      nxf++;
    strb_q = dbs_if_i.periph_data_strobe_n;
    if (!strb_q && !dbs_if_i.xcvr_en_n)
      check({29'h0, cur.w, dbs_if_i.xcvr_dir}, {29'h0, ACK_W32, rd});
    if (!strb_q && !rd && cur.w == ACK_W8)
      check({23'h0, dbs_if_i.single_byte_write_en_n, pd[15:8]},
        {24'h0, wd[31-8*a -: 8]});
    if (!strb_q && !rd && cur.w == ACK_W16)
      check({30'h0, dbs_if_i.upper_byte_write_en_n,
        dbs_if_i.lower_byte_write_en_n},
        {30'h0, a[0], cur.sz == SIZE_BYTE && !a[0]});
    if (!strb_q && !rd && cur.w == ACK_W16 && !a[0])
      check({16'h0, pd}, {16'h0, wd[31-8*a -: 16]});
  end

  // Cuts a hang short
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    size = SIZE_LONG_A;
    offs = 2'h0;
    rd = 1'b0;
    pw = ACK_W32;
    wd = 32'h0;
    pr = 32'h0;
    cur = ROWS[0];
    repeat (16) @(negedge CLK_SYS);
    RST = 1'b0;
    @(negedge CLK_SYS);
    chk_idle();
    for (int i = 0; i < NR; i++)
      access(ROWS[i], 0);
    // Second request while busy must be ignored
    access(ROWS[9], 1);
    // Reset in mid access, then a clean access
    access(ROWS[8], 2);
    @(negedge CLK_SYS);
    RST = 1'b0;
    @(negedge CLK_SYS);
    chk_idle();
    access(ROWS[8], 0);
    tally_and_finish();
  end
endmodule

// [tb/dbs_sva.sv]
`timescale 1ns/10ps
// Watches the sizer end of the bus pair
module dbs_sva
  import dbs_pkg::*;
(
  // Clock and reset
  input wire logic       CLK_SYS,
  input wire logic       RST,
  // Processor side
  input wire logic       sel_n,
  input wire logic       rd_wr,
  input wire logic       access_done_ack_n,
  input wire logic [3:0] dev_cpu_data_oe_n,
  // Peripheral side
  input wire logic [1:0] periph_byte_addr,
  input wire logic       upper_byte_write_en_n,
  input wire logic       lower_byte_write_en_n,
  input wire logic       single_byte_write_en_n,
  input wire logic       periph_data_strobe_n,
  input wire logic [1:0] periph_width_ack_n,
  input wire logic       dev_periph_data_oe_n
);
  logic       fin_r;
  logic [1:0] wid_r;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // Last cycle ended a transfer, and the width that it reported
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      fin_r <= 1'b0;
      wid_r <= ACK_W32;
    end else begin
      fin_r <= !periph_data_strobe_n && periph_width_ack_n != ACK_WAIT;
      if (!periph_data_strobe_n && periph_width_ack_n != ACK_WAIT)
        wid_r <= periph_width_ack_n;
    end
  end

  // A stretched transfer, and the gap between two transfers
  sequence s_wait;
    !periph_data_strobe_n && periph_width_ack_n == ACK_WAIT;
  endsequence
  sequence s_gap;
    $rose(periph_data_strobe_n) && access_done_ack_n
      ##1 !periph_data_strobe_n;
  endsequence

  a_ack_when_sel: assert property (
    !access_done_ack_n |-> !sel_n) else $error("Ack without select");
  a_ack_one_cycle: assert property (
    $fell(access_done_ack_n) |=> access_done_ack_n)
    else $error("Ack longer than one cycle");
  a_ack_after_xfer: assert property (
    $fell(access_done_ack_n) |-> fin_r) else $error("Ack before transfer");
  a_ack_bounded: assert property (
    $fell(sel_n) |-> ##[2:60] !access_done_ack_n)
    else $error("Access never acknowledged");
  a_wait_holds: assert property (
    s_wait |=> !periph_data_strobe_n && $stable(periph_byte_addr))
    else $error("Wait code not honoured");
  a_addr_advance: assert property (
    s_gap |-> periph_byte_addr != $past(periph_byte_addr, 2))
    else $error("Address not advanced");
  // Lower lanes only carry read data once the port is known narrow
  a_lower_lanes: assert property (
    dev_cpu_data_oe_n[1:0] != 2'h3 |->
      !access_done_ack_n && rd_wr && wid_r != ACK_W32)
    else $error("Lower lanes driven");
  a_we_in_strobe: assert property (
    !(upper_byte_write_en_n && lower_byte_write_en_n &&
      single_byte_write_en_n) |-> !periph_data_strobe_n && !rd_wr)
    else $error("Write enable outside write strobe");
  a_pdata_dir: assert property (
    !dev_periph_data_oe_n |-> !rd_wr) else $error("Drives data on read");
endmodule
